// File: hw/psp_pkg.sv
// Constants for the parallel slave port: register map, field positions, reset values
package psp_pkg;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned APB_DW = 32;
   localparam int unsigned CTRL_PINS = 3;

   // Register byte offsets
   localparam logic [7:0] OFF_PORT_CTRL = 8'h00;
   localparam logic [7:0] OFF_DATA_PORT = 8'h04;
   localparam logic [7:0] OFF_DATA_LAT = 8'h08;
   localparam logic [7:0] OFF_DATA_DIR = 8'h0c;
   localparam logic [7:0] OFF_CTRL_PINS = 8'h10;
   localparam logic [7:0] OFF_CTRL_LAT = 8'h14;
   localparam logic [7:0] OFF_CTRL_DIR = 8'h18;
   localparam logic [7:0] OFF_IRQ_FLAGS = 8'h1c;
   localparam logic [7:0] OFF_IRQ_EN = 8'h20;
   localparam logic [7:0] OFF_IRQ_PRIO = 8'h24;
   localparam logic [7:0] OFF_ANALOG_CFG = 8'h28;

   // slave_port_control fields
   localparam int unsigned BIT_INPUT_FULL = 7;
   localparam int unsigned BIT_OUTPUT_FULL = 6;
   localparam int unsigned BIT_OVERRUN = 5;
   localparam int unsigned BIT_SELECT = 4;
   // Interrupt flag, enable and priority all sit at this position
   localparam int unsigned BIT_PORT_IRQ = 7;

   // analog_pin_config field and the value that makes the control pins digital
   localparam int unsigned ANALOG_CFG_W = 3;
   localparam logic [2:0] ANALOG_CFG_DIGITAL = 3'h7;

   // Control pin positions within the control port
   localparam int unsigned PIN_READ_N = 0;
   localparam int unsigned PIN_WRITE_N = 1;
   localparam int unsigned PIN_SELECT_N = 2;

   // Reset values
   localparam logic [7:0] RST_PORT_CTRL = 8'h00;
   localparam logic [7:0] RST_DIR = 8'hff;
   localparam logic [7:0] RST_LAT = 8'h00;
   localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;
   localparam logic [7:0] RST_IRQ_EN = 8'h00;
   localparam logic [7:0] RST_IRQ_PRIO = 8'hff;
   localparam logic [2:0] RST_ANALOG_CFG = 3'h0;

   typedef enum logic [1:0] {ST_IDLE, ST_WRITING, ST_READING} port_state_t;
endpackage

// File: hw/pin_sync.sv
// Two-flop synchroniser for a group of asynchronous pin inputs
`timescale 1ns/1ps
module pin_sync #(
   parameter int unsigned WIDTH = 8,
   parameter logic [WIDTH-1:0] RST_VAL = '0
)(
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_q;

   initial
   begin
      if (WIDTH < 1)
         $error("pin_sync: WIDTH must be at least 1");
   end

   // First stage feeds only the second stage
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         meta_q <= RST_VAL;
         sync_o <= RST_VAL;
      end
      else if (ce)
      begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule

// File: hw/parallel_slave_port.sv
// Parallel slave port with its data and control ports, APB registers and interrupts
//
// Functional notes
// RL1: Select bit set turns the 8-bit data port into the slave port.
// RL2: Slave mode uses three control pins as read, write and chip select.
// RL3: Software sets the three low control direction bits to input first.
// RL4: Software sets analog pin config so control pins are digital.
// RL5: Write is taken when select and write strobe are first seen low.
// RL6: Read is taken when select and read strobe are first seen low.
// RL7: Strobes are asynchronous and synchronised before use.
// RL8: External processor sees one 8-bit latch, readable and writable.
// RL9: Control pins use TTL input buffers in slave mode.
// RL10: Input-full bit 7 set on external write, cleared when software reads.
// RL11: Output-full bit 6 high until external side reads software's word.
// RL12: Slave port works only in microcontroller mode, external bus off.
// RL13: Write onto unread input word sets overrun bit 5; software clears.
// RL14: Each finished transfer sets irq flag; enable and priority route it.
// RL15: Unused control register bits read zero and ignore writes.
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module parallel_slave_port
   import psp_pkg::*;
#(
   parameter int unsigned ADDR_W = 8
)(
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [APB_DW-1:0] pwdata,
   output logic [APB_DW-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // Device operating mode
   input wire logic microMode,
   // Data port pins
   input wire logic [DATA_W-1:0] dataIn,
   output logic [DATA_W-1:0] dataOut,
   output logic [DATA_W-1:0] dataOe,
   // Control port pins
   input wire logic [DATA_W-1:0] ctrlIn,
   output logic [DATA_W-1:0] ctrlOut,
   output logic [DATA_W-1:0] ctrlOe,
   output logic ctrlTtlBuffers,
   // Interrupts
   output logic irqHigh,
   output logic irqLow
);
   logic [DATA_W-1:0] dataPins;
   logic [DATA_W-1:0] ctrlPins;
   logic [DATA_W-1:0] dataLat_q;
   logic [DATA_W-1:0] dataDir_q;
   logic [DATA_W-1:0] ctrlLat_q;
   logic [DATA_W-1:0] ctrlDir_q;
   logic [DATA_W-1:0] inWord_q;
   logic [ANALOG_CFG_W-1:0] analogCfg_q;
   logic inFull_q;
   logic outFull_q;
   logic overrun_q;
   logic select_q;
   logic irqFlag_q;
   logic irqEn_q;
   logic irqPrio_q;
   port_state_t state_q;
   logic portActive;
   logic ctrlDigital;
   logic wrStrobe;
   logic rdStrobe;
   logic extWrStart;
   logic extRdStart;
   logic xferEnd;
   logic busAccess;
   logic busWrite;
   logic busRead;
   logic [DATA_W-1:0] wByte;
   logic [DATA_W-1:0] rByte;
   logic rHit;

   initial
   begin
      if (ADDR_W < 8)
         $error("parallel_slave_port: ADDR_W must be at least 8");
   end

   function automatic logic isReg(input logic [ADDR_W-1:0] a, input logic [7:0] off);
      isReg = (a == ADDR_W'(off));
   endfunction

   // Pins are asynchronous to clk; data is sampled through the same depth as the
   // strobes so the captured byte lines up with the detected write.
   pin_sync #(.WIDTH(DATA_W), .RST_VAL('1)) u_ctrl_sync (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .async_i(ctrlIn),
      .sync_o(ctrlPins)
   ); // RL7
   pin_sync #(.WIDTH(DATA_W), .RST_VAL('0)) u_data_sync (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .async_i(dataIn),
      .sync_o(dataPins)
   );

   // Strobes only count once software has made the control pins digital inputs
   assign ctrlDigital = (analogCfg_q == ANALOG_CFG_DIGITAL); // RL4
   assign portActive = select_q && microMode && ctrlDigital
      && (&ctrlDir_q[CTRL_PINS-1:0]); // RL1 RL3 RL12
   assign wrStrobe = portActive && !ctrlPins[PIN_SELECT_N] && !ctrlPins[PIN_WRITE_N]; // RL2
   assign rdStrobe = portActive && !ctrlPins[PIN_SELECT_N] && !ctrlPins[PIN_READ_N]; // RL2

   // Write has priority if a broken master asserts both strobes at once
   assign extWrStart = (state_q == ST_IDLE) && wrStrobe; // RL5
   assign extRdStart = (state_q == ST_IDLE) && !wrStrobe && rdStrobe; // RL6
   assign xferEnd = ((state_q == ST_WRITING) && !wrStrobe)
      || ((state_q == ST_READING) && !rdStrobe);

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         state_q <= ST_IDLE;
      else if (ce)
      begin
         unique case (state_q)
            ST_IDLE:
            begin
               if (extWrStart)
                  state_q <= ST_WRITING;
               else if (extRdStart)
                  state_q <= ST_READING;
            end
            ST_WRITING:
            begin
               if (!wrStrobe)
                  state_q <= ST_IDLE;
            end
            ST_READING:
            begin
               if (!rdStrobe)
                  state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // APB: one wait state so that read data and pready come from flops
   assign busAccess = psel && penable && pready;
   assign busWrite = busAccess && pwrite;
   assign busRead = busAccess && !pwrite;
   assign wByte = pwdata[DATA_W-1:0];

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end
      else if (ce)
      begin
         pready <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !rHit;
         if (psel && penable && !pready)
            prdata <= {{(APB_DW-DATA_W){1'b0}}, rByte};
      end
   end

   always_comb
   begin
      rHit = 1'b1;
      rByte = '0;
      if (isReg(paddr, OFF_PORT_CTRL))
         rByte = {inFull_q, outFull_q, overrun_q, select_q, 4'h0}; // RL15
      else if (isReg(paddr, OFF_DATA_PORT))
         rByte = portActive ? inWord_q : dataPins;
      else if (isReg(paddr, OFF_DATA_LAT))
         rByte = dataLat_q;
      else if (isReg(paddr, OFF_DATA_DIR))
         rByte = dataDir_q;
      else if (isReg(paddr, OFF_CTRL_PINS))
         rByte = ctrlDigital ? ctrlPins : {ctrlPins[DATA_W-1:CTRL_PINS], 3'h0};
      else if (isReg(paddr, OFF_CTRL_LAT))
         rByte = ctrlLat_q;
      else if (isReg(paddr, OFF_CTRL_DIR))
         rByte = ctrlDir_q;
      else if (isReg(paddr, OFF_IRQ_FLAGS))
         rByte = {irqFlag_q, 7'h00};
      else if (isReg(paddr, OFF_IRQ_EN))
         rByte = {irqEn_q, 7'h00};
      else if (isReg(paddr, OFF_IRQ_PRIO))
         rByte = {irqPrio_q, 7'h00};
      else if (isReg(paddr, OFF_ANALOG_CFG))
         rByte = {5'h00, analogCfg_q};
      else
         rHit = 1'b0;
   end

   // Plain software registers
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         select_q <= RST_PORT_CTRL[BIT_SELECT];
         dataDir_q <= RST_DIR;
         ctrlLat_q <= RST_LAT;
         ctrlDir_q <= RST_DIR;
         irqEn_q <= RST_IRQ_EN[BIT_PORT_IRQ];
         irqPrio_q <= RST_IRQ_PRIO[BIT_PORT_IRQ];
         analogCfg_q <= RST_ANALOG_CFG;
      end
      else if (ce && busWrite)
      begin
         if (isReg(paddr, OFF_PORT_CTRL))
            select_q <= wByte[BIT_SELECT]; // RL1
         if (isReg(paddr, OFF_DATA_DIR))
            dataDir_q <= wByte;
         if (isReg(paddr, OFF_CTRL_LAT))
            ctrlLat_q <= wByte;
         if (isReg(paddr, OFF_CTRL_DIR))
            ctrlDir_q <= wByte;
         if (isReg(paddr, OFF_IRQ_EN))
            irqEn_q <= wByte[BIT_PORT_IRQ];
         if (isReg(paddr, OFF_IRQ_PRIO))
            irqPrio_q <= wByte[BIT_PORT_IRQ];
         if (isReg(paddr, OFF_ANALOG_CFG))
            analogCfg_q <= wByte[ANALOG_CFG_W-1:0];
      end
   end

   // The output latch: software writes the output word here; the master's input word goes to inWord_q below
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         dataLat_q <= RST_LAT;
      else if (ce && busWrite
         && (isReg(paddr, OFF_DATA_PORT) || isReg(paddr, OFF_DATA_LAT)))
         dataLat_q <= wByte; // RL8
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         inWord_q <= '0;
      else if (ce && extWrStart)
         inWord_q <= dataPins; // RL5 RL8
   end

   // Input full: a master write in the same cycle as the software read wins
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         inFull_q <= RST_PORT_CTRL[BIT_INPUT_FULL];
      else if (ce)
      begin
         if (extWrStart)
            inFull_q <= 1'b1; // RL10
         else if (busRead && isReg(paddr, OFF_DATA_PORT) && portActive)
            inFull_q <= 1'b0; // RL10
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         overrun_q <= RST_PORT_CTRL[BIT_OVERRUN];
      else if (ce)
      begin
         if (extWrStart && inFull_q)
            overrun_q <= 1'b1; // RL13
         else if (busWrite && isReg(paddr, OFF_PORT_CTRL) && !wByte[BIT_OVERRUN])
            overrun_q <= 1'b0; // RL13
      end
   end

   // Output full: a fresh software word outranks a master read starting on the old one
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         outFull_q <= RST_PORT_CTRL[BIT_OUTPUT_FULL];
      else if (ce)
      begin
         if (busWrite && isReg(paddr, OFF_DATA_PORT) && portActive)
            outFull_q <= 1'b1; // RL11
         else if (extRdStart)
            outFull_q <= 1'b0; // RL11
      end
   end

   // Interrupt flag: write one to clear, a finishing transfer in that cycle wins
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         irqFlag_q <= RST_IRQ_FLAGS[BIT_PORT_IRQ];
      else if (ce)
      begin
         if (xferEnd)
            irqFlag_q <= 1'b1; // RL14
         else if (busWrite && isReg(paddr, OFF_IRQ_FLAGS) && wByte[BIT_PORT_IRQ])
            irqFlag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         irqHigh <= 1'b0;
         irqLow <= 1'b0;
      end
      else if (ce)
      begin
         irqHigh <= irqFlag_q && irqEn_q && irqPrio_q; // RL14
         irqLow <= irqFlag_q && irqEn_q && !irqPrio_q; // RL14
      end
   end

   // Pin drivers. In slave mode the data pins drive only during a master read,
   // and the three control pins are forced to inputs whatever the direction bits say.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         dataOut <= '0;
         dataOe <= '0;
         ctrlOut <= '0;
         ctrlOe <= '0;
         ctrlTtlBuffers <= 1'b0;
      end
      else if (ce)
      begin
         dataOut <= dataLat_q;
         ctrlOut <= ctrlLat_q;
         ctrlTtlBuffers <= portActive; // RL9
         if (portActive)
         begin
            dataOe <= (rdStrobe && !wrStrobe) ? '1 : '0; // RL6 RL8
            ctrlOe <= {~ctrlDir_q[DATA_W-1:CTRL_PINS], 3'h0}; // RL2
         end
         else
         begin
            dataOe <= ~dataDir_q;
            ctrlOe <= ~ctrlDir_q;
         end
      end
   end
endmodule

// File: testbench/parallel_slave_port_assertions.sv
// Port-level checks for the parallel slave port
`timescale 1ns/1ps
module parallel_slave_port_assertions
   import psp_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic [APB_DW-1:0] prdata,
   input wire logic pready,
   input wire logic microMode,
   input wire logic [DATA_W-1:0] dataOe,
   input wire logic [DATA_W-1:0] ctrlIn,
   input wire logic ctrlTtlBuffers,
   input wire logic irqHigh,
   input wire logic irqLow
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!nrst);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence access_s;
      psel && penable;
   endsequence
   // Select and read strobe low, write strobe high
   sequence ext_read_s;
      ctrlTtlBuffers && ctrlIn[2:0] == 3'b010;
   endsequence
   a_apb_one_wait: assert property (setup_s ##1 access_s |-> !pready ##1 pready)
      else $error("access phase did not end after one wait state");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("unused read data bits not zero");
   a_irq_one_line: assert property (!(irqHigh && irqLow))
      else $error("both interrupt levels raised together");
   a_mode_off_ttl: assert property ($fell(microMode) |=> !ctrlTtlBuffers)
      else $error("slave mode stayed active without microcontroller mode");
   a_ttl_needs_mode: assert property ($rose(ctrlTtlBuffers) |-> $past(microMode))
      else $error("ttl buffers enabled outside microcontroller mode");
   a_read_drives_bus: assert property (ext_read_s [*4] |-> dataOe == 8'hff)
      else $error("external read not answered by driving the data port");
   a_idle_no_drive: assert property ((ctrlTtlBuffers && ctrlIn[0]) [*4] |-> dataOe == 8'h00)
      else $error("data port driven while no external read is pending");
endmodule

bind parallel_slave_port parallel_slave_port_assertions i_chk (
   .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .prdata(prdata),
   .pready(pready), .microMode(microMode), .dataOe(dataOe), .ctrlIn(ctrlIn),
   .ctrlTtlBuffers(ctrlTtlBuffers), .irqHigh(irqHigh), .irqLow(irqLow));

// File: testbench/ext_cpu_model.sv
// Behavioural external 8-bit processor on the slave port pins
`timescale 1ns/1ps
module ext_cpu_model
   import psp_pkg::*;
(
   input wire logic clk,
   input wire logic [DATA_W-1:0] dataOut,
   input wire logic [DATA_W-1:0] dataOe,
   output logic [DATA_W-1:0] dataPins,
   output logic [CTRL_PINS-1:0] strobes
);
   logic drv = 1'b0;
   logic [DATA_W-1:0] wv = 8'h00;
   logic [DATA_W-1:0] junk = 8'h5a;
   initial
      strobes = 3'h7;
   // A released bus toggles so a stale byte never passes for a fresh one
   always @(posedge clk)
      junk <= ~junk;
   assign dataPins = drv ? wv : (dataOe & dataOut) | (~dataOe & junk);
   task automatic xfer(input logic wr, input logic [7:0] wd, output logic [7:0] rd);
      @(posedge clk);
      wv <= wd;
      drv <= wr;
      repeat (3) @(posedge clk);
      strobes <= wr ? 3'b001 : 3'b010;
      repeat (5) @(posedge clk);
      rd = dataPins;
      strobes <= 3'h7;
      @(posedge clk);
      drv <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
endmodule

// File: testbench/parallel_slave_port_tb.sv
// Self-checking bench for the parallel slave port
`timescale 1ns/1ps
module parallel_slave_port_tb
   import psp_pkg::*;
;
   typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic err;} row_t;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic microMode = 1'b1;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, ctrlTtlBuffers, irqHigh, irqLow, er;
   logic [7:0] dataPins, dataOut, dataOe, ctrlOut, ctrlOe, xb;
   logic [2:0] strobes;
   int miscompares = 0;
   int checksDone = 0;
   row_t rows [16] = '{'{1'b0, OFF_PORT_CTRL, 32'h00, 1'b0}, '{1'b0, OFF_DATA_DIR, 32'hff, 1'b0},
      '{1'b0, OFF_CTRL_DIR, 32'hff, 1'b0}, '{1'b0, OFF_IRQ_PRIO, 32'h80, 1'b0},
      '{1'b0, OFF_IRQ_FLAGS, 32'h00, 1'b0}, '{1'b0, OFF_IRQ_EN, 32'h00, 1'b0},
      '{1'b0, OFF_ANALOG_CFG, 32'h00, 1'b0}, '{1'b0, OFF_DATA_LAT, 32'h00, 1'b0},
      '{1'b0, 8'h40, 32'h00, 1'b1}, '{1'b1, 8'h40, 32'hff, 1'b1},
      '{1'b1, OFF_PORT_CTRL, 32'hff, 1'b0}, '{1'b0, OFF_PORT_CTRL, 32'h10, 1'b0},
      '{1'b1, OFF_ANALOG_CFG, 32'hff, 1'b0}, '{1'b0, OFF_ANALOG_CFG, 32'h07, 1'b0},
      '{1'b1, OFF_IRQ_EN, 32'h80, 1'b0}, '{1'b0, OFF_IRQ_EN, 32'h80, 1'b0}};

   always #5 clk = ~clk;

   parallel_slave_port i_parallel_slave_port (.clk(clk), .nrst(nrst), .ce(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .microMode(microMode),
      .dataIn(dataPins), .dataOut(dataOut), .dataOe(dataOe), .ctrlIn({5'h00, strobes}),
      .ctrlOut(ctrlOut), .ctrlOe(ctrlOe), .ctrlTtlBuffers(ctrlTtlBuffers),
      .irqHigh(irqHigh), .irqLow(irqLow));
   ext_cpu_model i_ext_cpu_model (.clk(clk), .dataOut(dataOut), .dataOe(dataOe),
      .dataPins(dataPins), .strobes(strobes));

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checksDone++;
      if (g !== e)
      begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk1(input logic g, input logic e);
      chk({31'h0, g}, {31'h0, e});
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] r, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      // A slave that never answers is left to the watchdog
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wrr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rd, er);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, rd, er);
      chk(rd, e);
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checksDone, miscompares);
      if (miscompares == 0 && checksDone > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      repeat (5000) @(posedge clk);
      miscompares++;
      end_sim;
   end

   initial
   begin
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      foreach (rows[i])
      begin
         apb(rows[i].wr, rows[i].a, rows[i].d, rd, er);
         if (!rows[i].wr)
            chk(rd, rows[i].d);
         chk1(er, rows[i].err);
      end
      $display("test register_map done");
      i_ext_cpu_model.xfer(1'b1, 8'hc3, xb);
      rdchk(OFF_PORT_CTRL, 32'h90);
      rdchk(OFF_IRQ_FLAGS, 32'h80);
      chk1(irqHigh, 1'b1);
      chk1(ctrlTtlBuffers, 1'b1);
      rdchk(OFF_DATA_PORT, 32'hc3);
      rdchk(OFF_PORT_CTRL, 32'h10);
      $display("test ext_write done");
      i_ext_cpu_model.xfer(1'b1, 8'h11, xb);
      i_ext_cpu_model.xfer(1'b1, 8'h22, xb);
      rdchk(OFF_PORT_CTRL, 32'hb0);
      wrr(OFF_PORT_CTRL, 32'h30);
      rdchk(OFF_PORT_CTRL, 32'hb0);
      wrr(OFF_PORT_CTRL, 32'h10);
      rdchk(OFF_PORT_CTRL, 32'h90);
      rdchk(OFF_DATA_PORT, 32'h22);
      $display("test overrun done");
      wrr(OFF_IRQ_FLAGS, 32'h80);
      wrr(OFF_IRQ_PRIO, 32'h00);
      rdchk(OFF_IRQ_FLAGS, 32'h00);
      chk1(irqHigh, 1'b0);
      wrr(OFF_DATA_PORT, 32'h5e);
      rdchk(OFF_PORT_CTRL, 32'h50);
      i_ext_cpu_model.xfer(1'b0, 8'h00, xb);
      chk({24'h0, xb}, 32'h5e);
      rdchk(OFF_PORT_CTRL, 32'h10);
      chk1(irqLow, 1'b1);
      chk1(irqHigh, 1'b0);
      wrr(OFF_IRQ_EN, 32'h00);
      rdchk(OFF_IRQ_FLAGS, 32'h80);
      chk1(irqLow, 1'b0);
      $display("test ext_read_irq done");
      microMode <= 1'b0;
      i_ext_cpu_model.xfer(1'b1, 8'h77, xb);
      rdchk(OFF_PORT_CTRL, 32'h10);
      chk1(ctrlTtlBuffers, 1'b0);
      microMode <= 1'b1;
      wrr(OFF_CTRL_DIR, 32'hfb);
      rdchk(OFF_CTRL_DIR, 32'hfb);
      chk1(ctrlTtlBuffers, 1'b0);
      chk({24'h0, ctrlOe}, 32'h04);
      wrr(OFF_CTRL_DIR, 32'hff);
      wrr(OFF_ANALOG_CFG, 32'h06);
      rdchk(OFF_ANALOG_CFG, 32'h06);
      chk1(ctrlTtlBuffers, 1'b0);
      wrr(OFF_ANALOG_CFG, 32'h07);
      rdchk(OFF_PORT_CTRL, 32'h10);
      chk1(ctrlTtlBuffers, 1'b1);
      wrr(OFF_PORT_CTRL, 32'h00);
      rdchk(OFF_PORT_CTRL, 32'h00);
      chk1(ctrlTtlBuffers, 1'b0);
      wrr(OFF_DATA_DIR, 32'h0f);
      wrr(OFF_CTRL_LAT, 32'ha5);
      rdchk(OFF_CTRL_LAT, 32'ha5);
      chk({24'h0, dataOe}, 32'hf0);
      chk({24'h0, dataOut}, 32'h5e);
      chk({24'h0, ctrlOut}, 32'ha5);
      $display("test mode_gating done");
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      rdchk(OFF_IRQ_EN, 32'h00);
      rdchk(OFF_IRQ_PRIO, 32'h80);
      $display("test mid_reset done");
      end_sim;
   end
endmodule
